/* File: core/didf_top.sv */
module didf_top
    import didf_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic first_digital_input_i,
    input wire logic second_digital_input_i,
    input wire logic [2:0] mode0_i,
    input wire logic [2:0] mode1_i,
    input wire logic [DIDF_HOLD_W-1:0] hold0_us_i,
    input wire logic [DIDF_HOLD_W-1:0] hold1_us_i,
    input wire logic shutdown_en_i,
    input wire logic system_pushbutton_i,
    input wire logic boot_done_i,
    input wire logic watchdog_en_i,
    input wire logic alarm_sel_i,
    input wire logic watchdog_alarm_i,
    input wire logic out0_level_i,
    output logic filt0_o,
    output logic filt1_o,
    output logic led0_o,
    output logic led1_o,
    output logic shutdown_req_o,
    output logic first_digital_output_o
);
    //--------------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------------
    logic [2:0] sync_q [DIDF_NCH];
    logic [2:0] sync_d [DIDF_NCH];
    logic [2:0] pb_q, pb_d;
    logic [DIDF_NCH-1:0] level_q, level_d;
    logic [DIDF_NCH-1:0] rise, fall;
    logic [DIDF_NCH-1:0] filt;
    logic [2:0] mode [DIDF_NCH];
    logic [DIDF_HOLD_W-1:0] hold [DIDF_NCH];
    logic [DIDF_PRE_W-1:0] pre_q, pre_d;
    logic tick_q, tick_d;
    logic boot_q, boot_d;
    logic inhibit_q, inhibit_d;
    logic shut_q, shut_d;
    logic do0_q, do0_d;
    logic [DIDF_NCH-1:0] filt_q;
    logic [DIDF_NCH-1:0] led_q;
    didf_tick_if tick_if ();

    assign mode[0] = mode0_i;
    assign mode[1] = mode1_i;
    assign hold[0] = hold0_us_i;
    assign hold[1] = hold1_us_i;
    assign tick_if.tick = tick_q;

    // A change counts only once stages two and three agree
    always_comb begin
        sync_d[0] = {sync_q[0][1:0], first_digital_input_i};
        sync_d[1] = {sync_q[1][1:0], second_digital_input_i};
        pb_d = {pb_q[1:0], system_pushbutton_i};
        level_d = level_q;
        for (int i = 0; i < DIDF_NCH; i++) begin
            if (sync_q[i][1] == sync_q[i][2]) begin
                level_d[i] = sync_q[i][2];
            end
        end
        rise = level_d & ~level_q;
        fall = ~level_d & level_q;
    end

    //--------------------------------------------------------------------
    // Microsecond tick divider
    //--------------------------------------------------------------------
    always_comb begin
        tick_d = (pre_q == DIDF_PRE_LAST); // RL3
        pre_d = tick_d ? '0 : pre_q + 1'b1;
    end

    //--------------------------------------------------------------------
    // Channel filters, one per input
    //--------------------------------------------------------------------
    for (genvar g = 0; g < DIDF_NCH; g++) begin : g_ch
        didf_chan u_chan (
            .clock_i(clock_i),
            .reset_i(reset_i),
            .tick_if(tick_if),
            .in_i(level_d[g]),
            .edge_rise_i(rise[g]),
            .edge_fall_i(fall[g]),
            .mode_i(mode[g]), // RL1 RL2
            .hold_us_i(hold[g]),
            .out_o(filt[g])
        );
    end

    //--------------------------------------------------------------------
    // Shutdown request, boot inhibit and alarm output
    //--------------------------------------------------------------------
    always_comb begin
        boot_d = boot_q | boot_done_i;
        // Pushbutton sampled only while boot runs; latched until reset
        inhibit_d = inhibit_q;
        if (!boot_q && pb_q[1] && pb_q[2]) begin
            inhibit_d = 1'b1; // RL11
        end
        shut_d = shutdown_en_i & filt[0] & ~inhibit_q; // RL9 RL11
        // Alarm only when both watchdog and the selection are on
        do0_d = (watchdog_en_i & alarm_sel_i) ? watchdog_alarm_i // RL10
                                              : out0_level_i;
    end

    // Registers for all state of the top level
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sync_q[0] <= DIDF_SYNC_RST;
            sync_q[1] <= DIDF_SYNC_RST;
            pb_q <= DIDF_SYNC_RST;
            level_q <= '0;
            pre_q <= '0;
            tick_q <= 1'b0;
            boot_q <= 1'b0;
            inhibit_q <= 1'b0;
            shut_q <= 1'b0;
            do0_q <= 1'b0;
            filt_q <= '0;
            led_q <= '0;
        end else begin
            sync_q[0] <= sync_d[0];
            sync_q[1] <= sync_d[1];
            pb_q <= pb_d;
            level_q <= level_d;
            pre_q <= pre_d;
            tick_q <= tick_d;
            boot_q <= boot_d;
            inhibit_q <= inhibit_d;
            shut_q <= shut_d;
            do0_q <= do0_d;
            filt_q <= filt;
            led_q <= level_q; // RL12
        end
    end

    assign filt0_o = filt_q[0];
    assign filt1_o = filt_q[1];
    assign led0_o = led_q[0];
    assign led1_o = led_q[1];
    assign shutdown_req_o = shut_q;
    assign first_digital_output_o = do0_q;
endmodule

/* File: core/didf_pkg.sv */
//------------------------------------------------------------------------
// Contract
// RL1 - Two input channels, each with independent filter mode and hold time.
// RL2 - Mode is off, stretch rise, stretch fall, stretch both, delay both.
// RL3 - Hold time 1..65535 us supplied by software, timed in microseconds.
// RL4 - Off mode passes the sampled input straight to the output.
// RL5 - Rising edge forces 1 for hold time, then output follows input.
// RL6 - Falling edge forces 0 for hold time, then output follows input.
// RL7 - Any edge takes new level, holds it, then follows input again.
// RL8 - First edge level held ignoring input; at expiry take input level.
// RL9 - First input may be enabled to request shutdown and power-off.
// RL10 - With watchdog enabled, first output may carry the watchdog alarm.
// RL11 - Pushbutton held at boot blocks shutdown requests from first input.
// RL12 - Each input indicator lit at logical 1, dark at logical 0.
// RL13 - Reset clears hold timers; outputs follow input; next edge is fresh.
//------------------------------------------------------------------------
package didf_pkg;
    localparam int unsigned DIDF_CLK_HZ = 40_000_000;
    localparam int unsigned DIDF_TICK_NS = 1000;
    localparam int unsigned DIDF_CLK_NS = 25;
    // Cycles per microsecond tick
    localparam int unsigned DIDF_TICK_CYC = DIDF_TICK_NS / DIDF_CLK_NS;
    localparam int unsigned DIDF_PRE_W = 6;
    localparam logic [DIDF_PRE_W-1:0] DIDF_PRE_LAST =
        DIDF_PRE_W'(DIDF_TICK_CYC - 1);
    localparam int unsigned DIDF_NCH = 2;
    localparam int unsigned DIDF_HOLD_W = 16;
    localparam logic [DIDF_HOLD_W-1:0] DIDF_HOLD_RST = 16'h0000;
    localparam logic [DIDF_HOLD_W-1:0] DIDF_HOLD_ONE = 16'h0001;
    localparam logic [2:0] DIDF_SYNC_RST = 3'h0;

    typedef enum logic [2:0] {
        DIDF_OFF = 3'h0,
        DIDF_STR_RISE = 3'h1,
        DIDF_STR_FALL = 3'h2,
        DIDF_STR_BOTH = 3'h3,
        DIDF_DLY_BOTH = 3'h4
    } didf_mode_e;

    // Channel filter states, Gray along pass -> hold
    typedef enum logic [0:0] {
        DIDF_PASS = 1'b0,
        DIDF_HOLD = 1'b1
    } didf_state_e;
endpackage

/* File: core/didf_tick_if.sv */
// Microsecond tick shared by the channel filters
interface didf_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

/* File: core/didf_chan.sv */
module didf_chan
    import didf_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    didf_tick_if.dst tick_if,
    input wire logic in_i,
    input wire logic edge_rise_i,
    input wire logic edge_fall_i,
    input wire logic [2:0] mode_i,
    input wire logic [DIDF_HOLD_W-1:0] hold_us_i,
    output logic out_o
);
    didf_state_e state_q, state_d;
    logic [DIDF_HOLD_W-1:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic trig;
    logic hit_rise;
    logic hit_fall;

    assign out_o = out_q;

    // Decide which edges start a hold for this mode
    always_comb begin
        hit_rise = 1'b0;
        hit_fall = 1'b0;
        unique case (mode_i)
            DIDF_STR_RISE: hit_rise = 1'b1; // RL5
            DIDF_STR_FALL: hit_fall = 1'b1; // RL6
            DIDF_STR_BOTH, DIDF_DLY_BOTH: begin
                hit_rise = 1'b1; // RL7 RL8
                hit_fall = 1'b1;
            end
            default: ;
        endcase
        trig = (hit_rise & edge_rise_i) | (hit_fall & edge_fall_i);
    end

    // Filter next state; hold counted in microsecond ticks
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        out_d = in_i;
        unique case (state_q)
            DIDF_PASS: begin
                out_d = in_i; // RL4
                if (trig) begin
                    state_d = DIDF_HOLD;
                    cnt_d = hold_us_i; // RL3
                end
            end
            DIDF_HOLD: begin
                out_d = out_q; // RL5 RL6 RL7 RL8
                // Off and undefined codes both end a running hold at once
                if (!(hit_rise | hit_fall)) begin
                    state_d = DIDF_PASS; // RL4
                    out_d = in_i;
                end else if (tick_if.tick) begin
                    // Zero hold is outside range; treat it as one tick
                    if (cnt_q <= DIDF_HOLD_ONE) begin
                        state_d = DIDF_PASS;
                        out_d = in_i; // RL8
                    end else begin
                        cnt_d = cnt_q - DIDF_HOLD_ONE;
                    end
                end
            end
        endcase
    end

    // Registers; reset clears the timer and makes the output transparent
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= DIDF_PASS; // RL13
            cnt_q <= DIDF_HOLD_RST;
            out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end
endmodule

/* File: test/didf_props.sv */
module didf_props
    import didf_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic first_digital_input_i,
    input wire logic second_digital_input_i,
    input wire logic [2:0] mode0_i,
    input wire logic [2:0] mode1_i,
    input wire logic [DIDF_HOLD_W-1:0] hold0_us_i,
    input wire logic [DIDF_HOLD_W-1:0] hold1_us_i,
    input wire logic shutdown_en_i,
    input wire logic watchdog_en_i,
    input wire logic alarm_sel_i,
    input wire logic watchdog_alarm_i,
    input wire logic out0_level_i,
    input wire logic filt0_o,
    input wire logic filt1_o,
    input wire logic led0_o,
    input wire logic shutdown_req_o,
    input wire logic first_digital_output_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic [2:0] off0_q;
    logic [2:0] off1_q;
    // -----------------------------------------------------------------
    // Edges spent in off mode; pass checks wait out the 5-edge pipe
    // -----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        off0_q <= (reset_i || mode0_i != DIDF_OFF) ? 3'h0 :
            (off0_q == 3'h7) ? off0_q : off0_q + 3'h1;
        off1_q <= (reset_i || mode1_i != DIDF_OFF) ? 3'h0 :
            (off1_q == 3'h7) ? off1_q : off1_q + 3'h1;
    end
    chk_off_pass0: assert property (off0_q > 3'h5 |->
        filt0_o == $past(first_digital_input_i, 5)) else $error("off pass 0");
    chk_off_pass1: assert property (off1_q > 3'h5 |->
        filt1_o == $past(second_digital_input_i, 5)) else $error("off pass 1");
    chk_led_level: assert property (off0_q > 3'h5 |->
        led0_o == $past(first_digital_input_i, 5)) else $error("led level");
    // Holds shorter than 2 us may legally end after one cycle of tick phase
    chk_rise_hold: assert property ($rose(filt0_o) && hold0_us_i > 16'h1
        && mode0_i == DIDF_STR_RISE && $past(mode0_i, 3) == DIDF_STR_RISE
        |=> filt0_o [*8]) else $error("rise stretch short");
    chk_fall_hold: assert property ($fell(filt1_o) && hold1_us_i > 16'h1
        && mode1_i == DIDF_STR_FALL && $past(mode1_i, 3) == DIDF_STR_FALL
        |=> !filt1_o [*8]) else $error("fall stretch short");
    chk_both_hold: assert property ($changed(filt0_o)
        && hold0_us_i > 16'h1
        && mode0_i == DIDF_STR_BOTH && $past(mode0_i, 3) == DIDF_STR_BOTH
        |=> $stable(filt0_o) [*8]) else $error("both stretch short");
    chk_shut_cause: assert property (shutdown_req_o |->
        filt0_o && $past(shutdown_en_i)) else $error("shutdown cause");
    chk_alarm_mux: assert property (!$past(reset_i) |->
        first_digital_output_o == $past(watchdog_en_i && alarm_sel_i ?
        watchdog_alarm_i : out0_level_i)) else $error("alarm mux");
    chk_reset_clear: assert property (disable iff (1'b0) reset_i |=>
        !filt0_o && !filt1_o && !led0_o && !shutdown_req_o)
        else $error("reset clear");
endmodule

/* File: test/didf_field_model.sv */
module didf_field_model (
    input wire logic clock_i,
    input wire logic [1:0] lvl_i,
    input wire logic [1:0] chat_i,
    output logic [1:0] di_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ph_q = 3'h0;
    // Bounce flips every third cycle so the synchroniser really sees edges
    always @(posedge clock_i) begin
        ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
    end
    assign di_o = (chat_i & {2{ph_q > 3'h2}}) | (~chat_i & lvl_i);
endmodule

/* File: test/didf_top_tb.sv */
module didf_top_tb
    import didf_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] lvl = 2'h0, chat = 2'h0, di;
    logic [2:0] mode0 = 3'h0, mode1 = 3'h0;
    logic [15:0] hold0 = 16'h2, hold1 = 16'h2;
    logic shut_en = 1'b0, pb = 1'b0, boot = 1'b0;
    logic wd_en = 1'b0, sel = 1'b0, alarm = 1'b0;
    logic lvl_out = 1'b0, filt0, filt1, led0, led1, req, do0;
    int errors = 0, tests_run = 0, cyc = 0;
    // ---------------------------------------------------------------
    // Clock, watchdog on the run length, field and device
    // ---------------------------------------------------------------
    always #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            conclude();
        end
    end
    didf_field_model i_didf_field_model (.clock_i(clock_i), .lvl_i(lvl),
        .chat_i(chat), .di_o(di));
    didf_top i_didf_top (.clock_i(clock_i), .reset_i(reset_i),
        .first_digital_input_i(di[0]), .second_digital_input_i(di[1]),
        .mode0_i(mode0), .mode1_i(mode1), .hold0_us_i(hold0),
        .hold1_us_i(hold1), .shutdown_en_i(shut_en),
        .system_pushbutton_i(pb), .boot_done_i(boot),
        .watchdog_en_i(wd_en), .alarm_sel_i(sel), .watchdog_alarm_i(alarm),
        .out0_level_i(lvl_out), .filt0_o(filt0), .filt1_o(filt1),
        .led0_o(led0), .led1_o(led1), .shutdown_req_o(req),
        .first_digital_output_o(do0));
    // Inputs move 2 ns after the edge so no sampling race is possible
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask
    task automatic chk(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    // Edge away from base, bounce during the hold, back to base
    task automatic pulse_chk(input bit ch, input logic [2:0] m, input logic b);
        if (ch)
            mode1 = m;
        else
            mode0 = m;
        lvl[ch] = b;
        step(110);
        lvl[ch] = !b;
        step(3);
        chat[ch] = 1'b1;
        step(9);
        chk("filt early", !b, ch ? filt1 : filt0);
        step(11);
        chat[ch] = 1'b0;
        lvl[ch] = b;
        step(17);
        chk("filt held", !b, ch ? filt1 : filt0);
        step(70);
        chk("filt after", b, ch ? filt1 : filt0);
    endtask
    task automatic conclude();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        step(8);
        reset_i = 1'b0;
        step(1);
        chk("reset filt0", 1'b0, filt0);
        lvl[0] = 1'b1;
        step(5);
        chk("off filt0", 1'b1, filt0);
        chk("led0", 1'b1, led0);
        chk("led1", 1'b0, led1);
        chk("off filt1", 1'b0, filt1);
        pulse_chk(0, DIDF_STR_RISE, 1'b0);
        pulse_chk(1, DIDF_STR_FALL, 1'b1);
        pulse_chk(0, DIDF_STR_BOTH, 1'b0);
        pulse_chk(0, DIDF_STR_BOTH, 1'b1);
        pulse_chk(1, DIDF_DLY_BOTH, 1'b0);
        pulse_chk(1, DIDF_DLY_BOTH, 1'b1);
        mode0 = DIDF_OFF;
        boot = 1'b1;
        shut_en = 1'b1;
        step(8);
        chk("shutdown req", 1'b1, req);
        shut_en = 1'b0;
        step(2);
        chk("shutdown off", 1'b0, req);
        reset_i = 1'b1;
        boot = 1'b0;
        step(8);
        reset_i = 1'b0;
        pb = 1'b1;
        step(6);
        boot = 1'b1;
        pb = 1'b0;
        shut_en = 1'b1;
        step(8);
        chk("inhibited req", 1'b0, req);
        for (int i = 0; i < 16; i++) begin
            {wd_en, sel, alarm, lvl_out} = i[3:0];
            step(1);
            chk("output0", (i[3] & i[2]) ? i[1] : i[0], do0);
        end
        conclude();
    end
endmodule

bind didf_top didf_props i_didf_props (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .first_digital_input_i(first_digital_input_i),
    .second_digital_input_i(second_digital_input_i),
    .mode0_i(mode0_i),
    .mode1_i(mode1_i),
    .hold0_us_i(hold0_us_i),
    .hold1_us_i(hold1_us_i),
    .shutdown_en_i(shutdown_en_i),
    .watchdog_en_i(watchdog_en_i),
    .alarm_sel_i(alarm_sel_i),
    .watchdog_alarm_i(watchdog_alarm_i),
    .out0_level_i(out0_level_i),
    .filt0_o(filt0_o),
    .filt1_o(filt1_o),
    .led0_o(led0_o),
    .shutdown_req_o(shutdown_req_o),
    .first_digital_output_o(first_digital_output_o)
);
